// ### verilog/sram_wr_defines.svh
// Purpose: Timing figures and bus widths for the async SRAM write host
// Assumes: 100 MHz clock, 10 ns period
// Notes: Times in ns as specified; cycle counts derived by rounding up
`ifndef SRAM_WR_DEFINES_SVH
`define SRAM_WR_DEFINES_SVH

`define CLK_PERIOD_NS 10
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Fast grade figures
`define T_CYCLE_F_NS 12
`define T_AV_END_F_NS 10
`define T_AV_END_GH_F_NS 9
`define T_EN_END_F_NS 10
`define T_EN_END_GH_F_NS 9
`define T_DV_END_F_NS 6
// Slow grade figures
`define T_CYCLE_S_NS 15
`define T_AV_END_S_NS 12
`define T_AV_END_GH_S_NS 10
`define T_EN_END_S_NS 12
`define T_EN_END_GH_S_NS 10
`define T_DV_END_S_NS 7
// Data hold
`define T_HOLD_NS 0

`define ADDR_W 18
`define DATA_W 16
`define LANE_W 2
`define PULSE_CNT_W 4

`endif

// ### verilog/sram_wr_pkg.sv
// Purpose: Types for the async SRAM write host
// Assumes: Constants live in sram_wr_defines.svh
// Notes: One-hot state codes
package sram_wr_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_SETUP = 4'h2,
		ST_PULSE = 4'h4,
		ST_RECOV = 4'h8
	} wr_state_t;
endpackage : sram_wr_pkg

// ### verilog/wr_timer_if.sv
// Purpose: Carrier between the sequencer and its pulse timer
// Assumes: Single clock domain
// Notes: load starts a count, done flags its end
`timescale 1ns/1ps
`include "sram_wr_defines.svh"
interface wr_timer_if;
	logic load;
	logic [`PULSE_CNT_W-1:0] count;
	logic done;
	modport ctrl (output load, output count, input done);
	modport timer (input load, input count, output done);
endinterface : wr_timer_if

// ### verilog/wr_timer.sv
// Purpose: Down-counter timing the asserted part of a write
// Assumes: count of zero or more cycles
// Notes: done is high while no count is running
`timescale 1ns/1ps
`include "sram_wr_defines.svh"
module wr_timer (
	input wire logic clk,
	input wire logic rst,
	wr_timer_if.timer tif
);
	logic [`PULSE_CNT_W-1:0] left_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			left_q <= '0;
		end else if (tif.load) begin
			left_q <= tif.count;
		end else if (left_q != '0) begin
			left_q <= left_q - 1'b1;
		end
	end

	assign tif.done = (left_q == '0);
endmodule : wr_timer

// ### verilog/sram_wr_host.sv
// Purpose: Host controller driving chip-enable-controlled SRAM writes
// Assumes: 100 MHz clk, synchronous active-high rst, one grade per build
// Notes: Output enable is held high, so the shorter output-enable-high
//   limits apply. Requests outside idle are ignored, not queued; the
//   requester must wait for ready. A request with no lane bits still
//   strobes both enables but writes no byte.
//
// Functional notes
// - Write cycle at least 12 or 15 ns
// - Address valid to write end 10/12 ns
// - With output enable high: 9/10 ns
// - Chip enable low to write end 10/12 ns
// - With output enable high: 9/10 ns
// - Data valid 6/7 ns before write end
// - Byte enable low 10/12, or 9/10 ns
// - Write enable stays high during reads
`timescale 1ns/1ps
`include "sram_wr_defines.svh"
module sram_wr_host import sram_wr_pkg::*; #(
	parameter bit SLOW_GRADE = 1'b0,
	parameter bit OE_HIGH = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic [`DATA_W-1:0] req_data,
	input wire logic [`LANE_W-1:0] req_lane_en,
	output logic req_ready,
	output logic wr_done,
	output logic [`ADDR_W-1:0] word_address,
	output logic chip_en_n,
	output logic write_en_n,
	output logic out_en_n,
	output logic low_lane_sel_n,
	output logic high_lane_sel_n,
	output logic [`DATA_W-1:0] data_bus_o,
	output logic data_bus_oe
);
	localparam int T_CYC = SLOW_GRADE ? `T_CYCLE_S_NS : `T_CYCLE_F_NS;
	localparam int T_AV = OE_HIGH ?
		(SLOW_GRADE ? `T_AV_END_GH_S_NS : `T_AV_END_GH_F_NS) :
		(SLOW_GRADE ? `T_AV_END_S_NS : `T_AV_END_F_NS);
	localparam int T_EN = OE_HIGH ?
		(SLOW_GRADE ? `T_EN_END_GH_S_NS : `T_EN_END_GH_F_NS) :
		(SLOW_GRADE ? `T_EN_END_S_NS : `T_EN_END_F_NS);
	localparam int T_DV = SLOW_GRADE ? `T_DV_END_S_NS : `T_DV_END_F_NS;

	// Enable pulse covers the longest of enable, address and data limits
	localparam int T_PULSE_MAX = (T_EN > T_AV) ? T_EN : T_AV;
	localparam int T_PULSE = (T_PULSE_MAX > T_DV) ? T_PULSE_MAX : T_DV;
	localparam int PULSE_CYC = `CYC_UP(T_PULSE);

	// Setup plus pulse plus recovery must reach the cycle time
	localparam int CYC_CYC = `CYC_UP(T_CYC);
	localparam int REC_RAW = CYC_CYC - PULSE_CYC - 1;
	localparam int REC_CYC = (REC_RAW > 0) ? REC_RAW : 0;
	// The timer counts the pulse cycles beyond the first one
	localparam logic [`PULSE_CNT_W-1:0] PULSE_CNT =
		`PULSE_CNT_W'(PULSE_CYC - 1);
	localparam logic [`PULSE_CNT_W-1:0] REC_CNT = `PULSE_CNT_W'(REC_CYC);

	wr_state_t state_q;
	logic [`PULSE_CNT_W-1:0] rec_q;
	wr_timer_if tif ();

	// Shared decodes: request taken, and last cycle of the enable pulse
	logic take;
	logic pulse_end;

	wr_timer u_timer (
		.clk(clk),
		.rst(rst),
		.tif(tif)
	);

	assign tif.load = (state_q == ST_SETUP);
	assign tif.count = PULSE_CNT;

	assign take = (state_q == ST_IDLE) && req_valid;
	assign pulse_end = (state_q == ST_PULSE) && tif.done;

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (req_valid) begin
						state_q <= ST_SETUP;
					end
				end
				// One setup cycle puts address, data and write enable out
				// before chip enable falls
				ST_SETUP: begin
					state_q <= ST_PULSE;
				end
				ST_PULSE: begin
					if (tif.done) begin
						state_q <= ST_RECOV;
					end
				end
				ST_RECOV: begin
					if (rec_q == '0) begin
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// Recovery padding keeps the whole cycle at or above its minimum
	always_ff @(posedge clk) begin
		if (rst) begin
			rec_q <= '0;
		end else if (pulse_end) begin
			rec_q <= REC_CNT;
		end else if (rec_q != '0) begin
			rec_q <= rec_q - 1'b1;
		end
	end

	// Address goes out one cycle ahead of chip enable and stays until
	// the next request, so it is valid across the whole enable pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			word_address <= '0;
		end else if (take) begin
			word_address <= req_addr;
		end
	end

	// Write data latched with the address, long before the pulse ends
	always_ff @(posedge clk) begin
		if (rst) begin
			data_bus_o <= '0;
		end else if (take) begin
			data_bus_o <= req_data;
		end
	end

	// Data driven from setup through the end of the pulse; hold is 0 ns
	always_ff @(posedge clk) begin
		if (rst) begin
			data_bus_oe <= 1'b0;
		end else begin
			data_bus_oe <= take || state_q == ST_SETUP ||
				(state_q == ST_PULSE && !tif.done);
		end
	end

	// Write enable leads chip enable and trails its rise
	always_ff @(posedge clk) begin
		if (rst) begin
			write_en_n <= 1'b1;
		end else if (take) begin
			write_en_n <= 1'b0;
		end else if (state_q == ST_RECOV || state_q == ST_IDLE) begin
			write_en_n <= 1'b1;
		end
	end

	// Lane selects span the whole write, so each byte pulse is long enough
	always_ff @(posedge clk) begin
		if (rst) begin
			low_lane_sel_n <= 1'b1;
			high_lane_sel_n <= 1'b1;
		end else if (take) begin
			low_lane_sel_n <= ~req_lane_en[0];
			high_lane_sel_n <= ~req_lane_en[1];
		end else if (state_q == ST_RECOV || state_q == ST_IDLE) begin
			low_lane_sel_n <= 1'b1;
			high_lane_sel_n <= 1'b1;
		end
	end

	// Chip enable falls after write enable and rises before it
	always_ff @(posedge clk) begin
		if (rst) begin
			chip_en_n <= 1'b1;
		end else begin
			chip_en_n <= !(state_q == ST_SETUP ||
				(state_q == ST_PULSE && !tif.done));
		end
	end

	// Output enable stays high so the shorter limits hold
	always_ff @(posedge clk) begin
		if (rst) begin
			out_en_n <= 1'b1;
		end else begin
			out_en_n <= 1'b1;
		end
	end

	// Ready tells the requester that idle will take a request next edge
	always_ff @(posedge clk) begin
		if (rst) begin
			req_ready <= 1'b0;
		end else begin
			req_ready <= (state_q == ST_IDLE && !req_valid) ||
				(state_q == ST_RECOV && rec_q == '0);
		end
	end

	// One-cycle completion strobe as chip enable rises
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_done <= 1'b0;
		end else begin
			wr_done <= pulse_end;
		end
	end
endmodule : sram_wr_host

// ### verif/sram_wr_chk.sv
// Purpose: Pin timing checks for sram_wr_host
// Assumes: Fast grade build, output enable held high
// Notes: Bound onto every sram_wr_host instance
`timescale 1ns/1ps
`include "sram_wr_defines.svh"
module sram_wr_chk (
	input wire logic clk,
	input wire logic rst,
	input wire logic [`ADDR_W-1:0] req_addr,
	input wire logic [`DATA_W-1:0] req_data,
	input wire logic [`LANE_W-1:0] req_lane_en,
	input wire logic wr_done,
	input wire logic [`ADDR_W-1:0] word_address,
	input wire logic chip_en_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic low_lane_sel_n,
	input wire logic high_lane_sel_n,
	input wire logic [`DATA_W-1:0] data_bus_o,
	input wire logic data_bus_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_cyc;
		$changed(word_address) |=> $stable(word_address) [*2];
	endproperty
	a_cyc: assert property (p_cyc) else $error("short cycle");
	property p_addr;
		$fell(chip_en_n) |-> $stable(word_address) ##1 $stable(word_address);
	endproperty
	a_addr: assert property (p_addr) else $error("address moved");
	property p_oe;
		out_en_n;
	endproperty
	a_oe: assert property (p_oe) else $error("output enable low");
	property p_en;
		$fell(chip_en_n) |=> $rose(chip_en_n);
	endproperty
	a_en: assert property (p_en) else $error("enable width");
	property p_data;
		$fell(chip_en_n) |-> data_bus_oe && $stable(data_bus_o);
	endproperty
	a_data: assert property (p_data) else $error("data late");
	property p_lane;
		$fell(write_en_n) |-> word_address == $past(req_addr) &&
			data_bus_o == $past(req_data) &&
			{high_lane_sel_n, low_lane_sel_n} == ~$past(req_lane_en);
	endproperty
	a_lane: assert property (p_lane) else $error("bad lanes");
	property p_we;
		!chip_en_n |-> !write_en_n ##1 !write_en_n;
	endproperty
	a_we: assert property (p_we) else $error("write enable order");
	property p_idle;
		wr_done |=> write_en_n;
	endproperty
	a_idle: assert property (p_idle) else $error("write enable stuck");
	c_wr: cover property ($fell(chip_en_n));
	c_lo: cover property ($fell(low_lane_sel_n) && high_lane_sel_n);
	c_b2b: cover property (wr_done ##[1:3] $fell(write_en_n));
endmodule : sram_wr_chk
bind sram_wr_host sram_wr_chk i_sram_wr_chk (.clk, .rst, .req_addr,
	.req_data, .req_lane_en, .wr_done, .word_address, .chip_en_n,
	.write_en_n, .out_en_n, .low_lane_sel_n, .high_lane_sel_n,
	.data_bus_o, .data_bus_oe);

// ### verif/sram_model.sv
// Purpose: Behavioural word store on the host's memory pins
// Assumes: Full address range, contents unknown at start
// Notes: drive shows when the store would own the data pins
`timescale 1ns/1ps
`include "sram_wr_defines.svh"
module sram_model (
	input wire logic chip_en_n,
	input wire logic write_en_n,
	input wire logic out_en_n,
	input wire logic low_lane_sel_n,
	input wire logic high_lane_sel_n,
	input wire logic [`ADDR_W-1:0] word_address,
	input wire logic [`DATA_W-1:0] data_bus,
	output logic drive
);
	logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
	assign drive = !chip_en_n && !out_en_n && write_en_n;
	always @(chip_en_n, write_en_n, low_lane_sel_n, high_lane_sel_n,
		word_address, data_bus) begin
		if (!chip_en_n && !write_en_n) begin
			if (!low_lane_sel_n)
				mem[word_address][7:0] = data_bus[7:0];
			if (!high_lane_sel_n)
				mem[word_address][15:8] = data_bus[15:8];
		end
	end
endmodule : sram_model

// ### verif/sram_wr_host_tb_top.sv
// Purpose: Self-checking bench for sram_wr_host
// Assumes: Fast grade build, 10 ns clock
// Notes: Released data pins show the inverse of the last word
`timescale 1ns/1ps
`include "sram_wr_defines.svh"
module sram_wr_host_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	logic [`ADDR_W-1:0] req_addr = '0;
	logic [`DATA_W-1:0] req_data = '0;
	logic [`LANE_W-1:0] req_lane_en = '0;
	logic req_ready, wr_done, chip_en_n, write_en_n, out_en_n, data_bus_oe;
	logic low_lane_sel_n, high_lane_sel_n;
	logic mem_drive;
	logic [`ADDR_W-1:0] word_address;
	logic [`DATA_W-1:0] data_bus_o;
	wire logic [`DATA_W-1:0] data_bus;
	int fails = 0;
	int num_checks = 0;
	always #5 clk = ~clk;
	assign #1 data_bus = data_bus_oe ? data_bus_o : ~data_bus_o;
	sram_wr_host i_sram_wr_host (.clk, .rst, .req_valid, .req_addr,
		.req_data, .req_lane_en, .req_ready, .wr_done, .word_address,
		.chip_en_n, .write_en_n, .out_en_n, .low_lane_sel_n,
		.high_lane_sel_n, .data_bus_o, .data_bus_oe);
	sram_model i_sram_model (.chip_en_n, .write_en_n, .out_en_n,
		.low_lane_sel_n, .high_lane_sel_n, .word_address, .data_bus,
		.drive(mem_drive));
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic hold(input bit done);
		int n;
		n = 0;
		while ((done ? wr_done : req_ready) !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > 20) begin
				fails++;
				results();
			end
		end
	endtask : hold
	task automatic wr(input logic [17:0] a, input logic [15:0] d,
		input logic [1:0] l);
		hold(1'b0);
		req_addr = a;
		req_data = d;
		req_lane_en = l;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		hold(1'b1);
	endtask : wr
	task automatic t_idle();
		logic [7:0] pins;
		pins = {wr_done, req_ready, write_en_n, chip_en_n, out_en_n,
			data_bus_oe, high_lane_sel_n, low_lane_sel_n};
		chk(16'(pins), 16'h007b);
		$display("idle test done");
	endtask : t_idle
	task automatic t_word();
		wr(18'h3ffff, 16'ha55a, 2'h3);
		chk(16'({chip_en_n, data_bus_oe, write_en_n}), 16'h0004);
		chk(i_sram_model.mem[18'h3ffff], 16'ha55a);
		$display("word test done");
	endtask : t_word
	task automatic t_lane();
		wr(18'h00005, 16'h1234, 2'h3);
		wr(18'h00005, 16'habcd, 2'h1);
		chk(i_sram_model.mem[18'h00005], 16'h12cd);
		wr(18'h00005, 16'h5678, 2'h2);
		chk(i_sram_model.mem[18'h00005], 16'h56cd);
		$display("lane test done");
	endtask : t_lane
	task automatic t_b2b();
		wr(18'h00006, 16'h1111, 2'h3);
		wr(18'h00007, 16'h2222, 2'h3);
		chk(i_sram_model.mem[18'h00006], 16'h1111);
		chk(i_sram_model.mem[18'h00007], 16'h2222);
		chk(16'(mem_drive), 16'h0000);
		$display("back to back test done");
	endtask : t_b2b
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_idle();
		t_word();
		t_lane();
		t_b2b();
		results();
	end
endmodule : sram_wr_host_tb_top
